// >>> eba_pkg.sv
// package of constants and types for the expansion bus central arbiter
package eba_pkg;
  localparam int unsigned LVL_W = 4;
  localparam logic [3:0] DEFAULT_LEVEL = 4'hf;
  localparam logic [3:0] ALL_RELEASED = 4'hf;
  localparam int unsigned SETTLE_CYCLES = 2;
  localparam int unsigned SETTLE_W = 2;
  localparam int unsigned LOCKOUT_CYCLES_DEFAULT = 100000;
  localparam int unsigned SLOT_RESET_CYCLES = 16;
  localparam int unsigned CNT_W = 32;
  localparam logic [31:0] CNT_ZERO = 32'h0;
  localparam logic [31:0] CNT_ONE = 32'h1;

  typedef enum logic [2:0] {
    EBA_PARK = 3'b000,
    EBA_WAIT_IDLE = 3'b001,
    EBA_ARB = 3'b010,
    EBA_GRANT = 3'b011,
    EBA_TIMEOUT = 3'b100
  } eba_state_t;
endpackage

// >>> eba_cnt_if.sv
// interface carrying the lockout counter controls and status between modules
`timescale 1ns/1ns
interface eba_cnt_if;
  logic clear;
  logic count;
  logic expired;
  modport owner (output clear, output count, input expired);
  modport counter (input clear, input count, output expired);
endinterface

// >>> eba_lockout_cnt.sv
// lockout timer counting cycles while a processor access is held off
`timescale 1ns/1ns
module eba_lockout_cnt #(
  parameter logic [31:0] LIMIT = 32'd100000
) (
  input wire logic clk,
  input wire logic rst_n,
  eba_cnt_if.counter cnt
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic expired_reg;
  logic expired_next;

  // count while asked, stop at the limit, clear on request
  always_comb begin
    cnt_next = cnt_reg;
    expired_next = expired_reg;
    if (cnt.clear) begin
      cnt_next = eba_pkg::CNT_ZERO;
      expired_next = 1'b0;
    end else if (cnt.count) begin
      if (cnt_reg >= LIMIT - eba_pkg::CNT_ONE) begin
        expired_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + eba_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 32'h0;
      expired_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      expired_reg <= expired_next;
    end
  end

  assign cnt.expired = expired_reg;
endmodule

// >>> eba_arbiter.sv
// central arbitration sequencer of the host io controller
`timescale 1ns/1ns
module eba_arbiter #(
  parameter logic [31:0] LOCKOUT_CYCLES = 32'd100000,
  parameter int unsigned SLOT_RST_CYCLES = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic preempt_n,
  input wire logic burst_n,
  input wire logic bus_busy,
  input wire logic [3:0] arb_bus_in,
  input wire logic dma_slave_won,
  input wire logic cpu_req,
  input wire logic cpu_done,
  input wire logic timeout_clear,
  output logic arb_gnt,
  output logic [3:0] arb_bus_out,
  output logic [3:0] arb_bus_oe,
  output logic [3:0] owner_level,
  output logic cpu_owns,
  output logic cpu_grant,
  output logic dma_cycle_drive,
  output logic bus_timeout,
  output logic slot_reset
);
  logic rst_s1_reg;
  logic rst_s2_reg;
  logic rst_n;
  eba_pkg::eba_state_t state_reg;
  eba_pkg::eba_state_t state_next;
  logic [1:0] settle_reg;
  logic [1:0] settle_next;
  logic [3:0] owner_reg;
  logic [3:0] owner_next;
  logic dma_reg;
  logic dma_next;
  logic cpu_act_reg;
  logic cpu_act_next;
  logic timeout_reg;
  logic timeout_next;
  logic [4:0] srst_reg;
  logic [4:0] srst_next;
  logic req;
  logic burst;
  eba_cnt_if cnt_bus ();

  // reset release through two flip-flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  // shared lines are active low; adapters request and hold burst
  assign req = !preempt_n;
  assign burst = !burst_n;

  // lockout counter runs while the processor waits for the bus
  assign cnt_bus.count = cpu_req && !cpu_owns && !timeout_reg;
  assign cnt_bus.clear = cpu_owns || timeout_reg;

  eba_lockout_cnt #(
    .LIMIT(LOCKOUT_CYCLES)
  ) u_lockout (
    .clk(clk),
    .rst_n(rst_n),
    .cnt(cnt_bus)
  );

  // arbitration sequencing; priority itself is resolved on the shared bus
  always_comb begin
    state_next = state_reg;
    settle_next = settle_reg;
    owner_next = owner_reg;
    dma_next = dma_reg;
    cpu_act_next = cpu_act_reg;
    timeout_next = timeout_reg;
    srst_next = srst_reg;
    if (cpu_act_reg && cpu_done) begin
      cpu_act_next = 1'b0;
    end
    unique case (state_reg)
      eba_pkg::EBA_PARK: begin
        if (req) begin
          state_next = eba_pkg::EBA_WAIT_IDLE;
        end
      end
      eba_pkg::EBA_WAIT_IDLE: begin
        if (!bus_busy) begin
          state_next = eba_pkg::EBA_ARB;
          settle_next = 2'h0;
        end
      end
      eba_pkg::EBA_ARB: begin
        if (cpu_req && !cpu_act_reg) begin
          cpu_act_next = 1'b1;
        end
        if (settle_reg != 2'(eba_pkg::SETTLE_CYCLES)) begin
          settle_next = settle_reg + 2'h1;
        end else if (!cpu_act_reg && !(cpu_req && !cpu_act_reg)) begin
          state_next = eba_pkg::EBA_GRANT;
          owner_next = req ? arb_bus_in : eba_pkg::DEFAULT_LEVEL;
          dma_next = req && dma_slave_won;
        end
      end
      eba_pkg::EBA_GRANT: begin
        if (owner_reg == eba_pkg::DEFAULT_LEVEL && !req) begin
          state_next = eba_pkg::EBA_PARK;
        end else if (!bus_busy && !burst) begin
          state_next = eba_pkg::EBA_WAIT_IDLE;
          dma_next = 1'b0;
        end
      end
      eba_pkg::EBA_TIMEOUT: begin
        if (srst_reg != 5'h0) begin
          srst_next = srst_reg - 5'h1;
        end
        if (timeout_clear && srst_reg == 5'h0) begin
          timeout_next = 1'b0;
          state_next = eba_pkg::EBA_PARK;
          owner_next = eba_pkg::DEFAULT_LEVEL;
        end
      end
      default: begin
        state_next = eba_pkg::EBA_PARK;
      end
    endcase
    if (cnt_bus.expired && !timeout_reg) begin
      timeout_next = 1'b1;
      state_next = eba_pkg::EBA_TIMEOUT;
      srst_next = 5'(SLOT_RST_CYCLES);
      dma_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= eba_pkg::EBA_PARK;
      settle_reg <= 2'h0;
      owner_reg <= 4'hf;
      dma_reg <= 1'b0;
      cpu_act_reg <= 1'b0;
      timeout_reg <= 1'b0;
      srst_reg <= 5'h0;
    end else begin
      state_reg <= state_next;
      settle_reg <= settle_next;
      owner_reg <= owner_next;
      dma_reg <= dma_next;
      cpu_act_reg <= cpu_act_next;
      timeout_reg <= timeout_next;
      srst_reg <= srst_next;
    end
  end

  // line levels: grant high, arbitrate low; timeout forces arbitrate
  assign arb_gnt = !(state_reg == eba_pkg::EBA_ARB || timeout_reg);
  // the controller joins arbitration at level 0xf, which drives nothing low
  assign arb_bus_out = 4'h0;
  assign arb_bus_oe = (state_reg == eba_pkg::EBA_ARB) ? ~eba_pkg::DEFAULT_LEVEL : 4'h0;
  assign owner_level = owner_reg;
  assign cpu_owns = (state_reg == eba_pkg::EBA_PARK) ||
                    (state_reg == eba_pkg::EBA_GRANT && owner_reg == eba_pkg::DEFAULT_LEVEL) ||
                    cpu_act_reg;
  assign cpu_grant = cpu_req && (cpu_owns || timeout_reg);
  assign dma_cycle_drive = dma_reg && state_reg == eba_pkg::EBA_GRANT;
  assign bus_timeout = timeout_reg;
  assign slot_reset = timeout_reg && srst_reg != 5'h0;
endmodule

// >>> eba_chk.sv
// concurrent checks on the arbiter's ports
`timescale 1ns/1ns
module eba_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic burst_n,
  input wire logic bus_busy,
  input wire logic [3:0] arb_bus_in,
  input wire logic arb_gnt,
  input wire logic [3:0] owner_level,
  input wire logic cpu_req,
  input wire logic cpu_owns,
  input wire logic cpu_grant,
  input wire logic bus_timeout,
  input wire logic slot_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // arbitration sequencing
  a_arb_after_idle: assert property ($fell(arb_gnt) && !bus_timeout |-> !$past(bus_busy))
    else $error("arbitrate while busy");
  a_arb_min_len: assert property ($fell(arb_gnt) |-> !arb_gnt [*3])
    else $error("arbitrate phase short");
  a_grant_lowest: assert property ($rose(arb_gnt) && !$past(bus_timeout) |->
    owner_level == $past(arb_bus_in))
    else $error("wrong owner");
  a_burst_holds: assert property (arb_gnt && owner_level != 4'hf && !burst_n |=>
    arb_gnt || bus_timeout)
    else $error("rearbitrated in burst");
  a_park_level: assert property (arb_gnt && cpu_owns |-> owner_level == 4'hf)
    else $error("park level");
  // processor access and lockout recovery
  a_cpu_access: assert property (bus_timeout && cpu_req |-> cpu_grant)
    else $error("cpu grant");
  a_timeout_act: assert property ($rose(bus_timeout) |-> slot_reset && !arb_gnt)
    else $error("timeout action");
  a_slot_rst_len: assert property ($rose(slot_reset) |->
    slot_reset [*8] ##8 slot_reset ##1 !slot_reset)
    else $error("slot reset length");
  c_burst: cover property (!burst_n && arb_gnt);
  c_timeout: cover property ($rose(bus_timeout));
  c_cpu_timeout: cover property (cpu_grant && bus_timeout);
  c_cpu_stretch: cover property (cpu_grant && !arb_gnt && !bus_timeout);
endmodule
bind eba_arbiter eba_chk eba_chk_inst (.*);

// >>> eba_adapter.sv
// adapter-side arbiters and masters sharing the expansion bus
`timescale 1ns/1ns
module eba_adapter (
  input wire logic clk,
  input wire logic arb_gnt,
  input wire logic slot_reset,
  input wire logic [15:0] req,
  input wire logic burst,
  input wire logic [7:0] hold,
  output logic preempt_n,
  output logic burst_n,
  output logic bus_busy,
  output logic [3:0] arb_bus_in
);
  logic [15:0] served = 16'h0;
  logic [7:0] cnt = 8'h0;
  logic gnt_q = 1'b1;
  logic [3:0] low;
  logic win;
  // lowest pending level wins; released lines pull up to 0xf
  always_comb begin
    low = 4'hf;
    for (int i = 15; i >= 0; i--) if (req[i] && !served[i]) low = 4'(i);
  end
  assign win = arb_gnt && !gnt_q && low != 4'hf;
  assign preempt_n = ~|(req & ~served);
  assign arb_bus_in = arb_gnt ? 4'hf : low;
  assign bus_busy = win || cnt != 8'h0;
  assign burst_n = !(burst && bus_busy);
  // winner runs its cycles for hold clocks; slot reset aborts it
  // served mask rotates service among requesters
  // hold is at most 255 clocks, well under the default 100000-cycle lockout limit
  always @(posedge clk) begin
    gnt_q <= arb_gnt;
    served <= served & req;
    if (slot_reset) cnt <= 8'h0;
    else if (cnt != 8'h0) cnt <= cnt - 8'h1;
    else if (win) begin
      cnt <= hold;
      served[low] <= 1'b1;
    end
  end
endmodule

// >>> tb_top.sv
// testbench running the arbiter against the adapter model
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] req = 16'h0;
  logic burst = 1'b0;
  logic [7:0] hold = 8'h4;
  logic dma_slave_won = 1'b0;
  logic cpu_req = 1'b0;
  logic cpu_done = 1'b0;
  logic timeout_clear = 1'b0;
  logic preempt_n, burst_n, bus_busy, arb_gnt, cpu_owns, cpu_grant, dma_cycle_drive;
  logic bus_timeout, slot_reset;
  logic [3:0] arb_bus_in, owner_level, arb_bus_out, arb_bus_oe;
  int err_count = 0;
  int n_compared = 0;
  always #5 clk = ~clk;
  eba_arbiter #(.LOCKOUT_CYCLES(32'd50), .SLOT_RST_CYCLES(16)) eba_arbiter_inst (
    .*);
  eba_adapter eba_adapter_inst (.*);
  task chk(input logic ok, input string m);
    n_compared++;
    if (!ok) begin
      err_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // two requesters, the first a dma slave bursting
  task t_arb;
    @(posedge clk);
    dma_slave_won <= 1'b1;
    burst <= 1'b1;
    req <= 16'h0208;
    repeat (300) if (arb_gnt) @(posedge clk) #1;
    chk(arb_gnt === 1'b0, "no arbitrate");
    repeat (300) if (!arb_gnt) @(posedge clk) #1;
    chk(owner_level === 4'h3 && dma_cycle_drive === 1'b1, "winner 3");
    @(posedge clk);
    dma_slave_won <= 1'b0;
    repeat (300) if (owner_level !== 4'h9) @(posedge clk) #1;
    chk(owner_level === 4'h9 && dma_cycle_drive === 1'b0, "winner 9");
    @(posedge clk);
    req <= 16'h0;
    burst <= 1'b0;
    repeat (300) if (!cpu_owns || !arb_gnt) @(posedge clk) #1;
    chk(owner_level === 4'hf && arb_gnt === 1'b1, "park");
    $display("test arb done");
  endtask
  // processor access during arbitrate stretches the phase
  task t_stretch;
    @(posedge clk);
    hold <= 8'h4;
    burst <= 1'b0;
    req <= 16'h0002;
    repeat (300) if (arb_gnt) @(posedge clk) #1;
    @(posedge clk);
    cpu_req <= 1'b1;
    repeat (6) @(posedge clk) #1;
    chk(arb_gnt === 1'b0 && cpu_grant === 1'b1, "stretch");
    chk(arb_bus_oe === 4'h0 && arb_bus_out === 4'h0, "level 0xf");
    @(posedge clk);
    cpu_done <= 1'b1;
    cpu_req <= 1'b0;
    @(posedge clk);
    cpu_done <= 1'b0;
    repeat (20) if (!arb_gnt) @(posedge clk) #1;
    chk(arb_gnt === 1'b1 && owner_level === 4'h1, "winner 1");
    @(posedge clk);
    req <= 16'h0;
    repeat (300) if (!cpu_owns || !arb_gnt) @(posedge clk) #1;
    chk(owner_level === 4'hf && arb_gnt === 1'b1, "park 2");
    $display("test stretch done");
  endtask
  // long burst locks the processor out until timeout
  task t_timeout;
    @(posedge clk);
    hold <= 8'hc8;
    burst <= 1'b1;
    req <= 16'h0020;
    repeat (300) if (owner_level !== 4'h5) @(posedge clk) #1;
    @(posedge clk);
    cpu_req <= 1'b1;
    repeat (300) if (!bus_timeout) @(posedge clk) #1;
    @(posedge clk) #1;
    chk(arb_gnt === 1'b0 && slot_reset === 1'b1, "timeout");
    chk(cpu_grant === 1'b1, "cpu access");
    cpu_done <= 1'b1;
    cpu_req <= 1'b0;
    req <= 16'h0;
    burst <= 1'b0;
    @(posedge clk);
    cpu_done <= 1'b0;
    repeat (40) if (slot_reset) @(posedge clk) #1;
    chk(bus_timeout === 1'b1, "flag sticky");
    @(posedge clk);
    timeout_clear <= 1'b1;
    @(posedge clk);
    timeout_clear <= 1'b0;
    @(posedge clk) #1;
    repeat (300) if (!arb_gnt) @(posedge clk) #1;
    chk(bus_timeout === 1'b0 && arb_gnt === 1'b1, "cleared");
    $display("test timeout done");
  endtask
  task test_done;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk) #1;
    chk(owner_level === 4'hf && cpu_owns === 1'b1 && bus_timeout === 1'b0, "reset");
    t_arb;
    t_stretch;
    t_timeout;
    test_done;
  end
  initial begin
    #50000;
    err_count++;
    test_done;
  end
endmodule
